/* hw/sfc_pkg.sv */
// Shared constants and types for the serial flash command block.
// Assumes a single-bit serial link and a 25 MHz system clock.
package sfc_pkg;
    // Instruction codes
    localparam logic [7:0] OP_STATUS_READ  = 8'h05;
    localparam logic [7:0] OP_STATUS_WRITE = 8'h01;
    localparam logic [7:0] OP_READ         = 8'h03;
    localparam logic [7:0] OP_FAST_READ    = 8'h0B;
    localparam logic [7:0] OP_PAGE_WRITE   = 8'h02;
    localparam logic [7:0] OP_WRITE_UNLOCK = 8'h06;
    localparam logic [7:0] OP_WRITE_LOCK   = 8'h04;
    localparam logic [7:0] OP_SECTOR_CLEAR = 8'hD8;
    localparam logic [7:0] OP_CHIP_CLEAR   = 8'hC7;
    // Whole bytes per frame (opcode included)
    localparam logic [3:0] BYTES_CMD  = 4'h1;
    localparam logic [3:0] BYTES_WSR  = 4'h2;
    localparam logic [3:0] BYTES_ADDR = 4'h4;
    localparam logic [3:0] BYTES_FAST = 4'h5;
    localparam logic [3:0] BYTES_MAX  = 4'hF;
    // Status byte layout
    localparam int SB_BUSY = 0;
    localparam int SB_WEL  = 1;
    localparam int SB_BP   = 2;
    localparam int SB_SRP  = 7;
    localparam int BP_W    = 3;
    // Reset values
    localparam logic [2:0] BP_RST  = 3'h0;
    localparam logic       SRP_RST = 1'b0;
    localparam logic [2:0] SYNC_RST = 3'h6; // {cs_n, wp_n, toggle}
    // Array geometry
    localparam int ADDR_W_DEF = 21;
    localparam int SECTOR_AW  = 16;
    localparam int PAGE_AW    = 8;
    localparam logic [7:0] ERASED = 8'hFF;
    // Self-timed cycle lengths
    localparam int CLK_PERIOD_NS      = 40;
    localparam int STATUS_WRITE_TIME_NS = 8000;
    localparam int PAGE_WRITE_TIME_NS   = 20000;
    localparam int STATUS_WRITE_CYC =
        (STATUS_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PAGE_WRITE_CYC =
        (PAGE_WRITE_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    // Internal cycle states, Gray along idle-wsr-prog-erase
    typedef enum logic [1:0] {
        SFC_IDLE  = 2'b00,
        SFC_WSR   = 2'b01,
        SFC_PROG  = 2'b11,
        SFC_ERASE = 2'b10
    } sfc_state_t;
    // Status carried between domains
    typedef struct packed {
        logic       status_lock_bit;
        logic [2:0] bp;
        logic       write_unlock_latch;
        logic       busy;
    } sfc_stat_t;
    // Summary of the last frame, held while deselected
    typedef struct packed {
        logic [7:0]  op;
        logic [3:0]  nbytes;
        logic [2:0]  bits;
        logic [23:0] addr;
        logic [7:0]  data;
    } sfc_frame_t;
endpackage

/* hw/sfc_cmd.sv */
// Serial flash instruction interpreter: status, reads, page program.
// Assumes i_sck stops while i_cs_n is high and i_rst is held with
// i_cs_n high for at least four i_clk edges.
`timescale 1ns/1ps
module sfc_cmd #(
    parameter int ADDR_W           = sfc_pkg::ADDR_W_DEF,
    parameter int STATUS_WRITE_CYC = sfc_pkg::STATUS_WRITE_CYC,
    parameter int PAGE_WRITE_CYC   = sfc_pkg::PAGE_WRITE_CYC
) (
    // System clock and reset
    input  wire logic i_clk,
    input  wire logic i_rst,
    // Serial link
    input  wire logic i_sck,
    input  wire logic i_cs_n,
    input  wire logic i_si,
    input  wire logic i_wp_n,
    // Serial data out pin
    output logic      o_so,
    output logic      o_so_oe
);
    localparam int MEM_BYTES = 1 << ADDR_W;
    localparam int PAGE_BYTES = 1 << sfc_pkg::PAGE_AW;
    // Sector span, clipped to the array when the array is smaller
    localparam int SEC_BYTES = (ADDR_W > sfc_pkg::SECTOR_AW) ? (1 << sfc_pkg::SECTOR_AW) : MEM_BYTES;
    localparam logic [ADDR_W-1:0] SEC_MASK = ADDR_W'(SEC_BYTES - 1);

    // Array and page staging buffer
    logic [7:0]            mem [0:MEM_BYTES-1];
    logic [7:0]            pbuf [0:PAGE_BYTES-1];
    logic [PAGE_BYTES-1:0] pmask;                // Bytes received this frame

    // Protected when inside the top span chosen by the protect bits
    function automatic logic prot_hit(input logic [ADDR_W-1:0] a, input logic [2:0] bp);
        logic [ADDR_W:0] span;
        span = '0;
        if (bp != 3'h0) begin
            span = (ADDR_W+1)'(MEM_BYTES) >> (3'h7 - bp);
        end
        return (bp != 3'h0) && ({1'b0, a} >= ((ADDR_W+1)'(MEM_BYTES) - span));
    endfunction

    // Link-domain state
    logic             started;     // First edge of frame seen
    logic [2:0]       bit_cnt;     // Bits of current byte
    logic [3:0]       byte_cnt;    // Whole bytes, saturating
    logic [7:0]       sh;          // Input shifter
    logic [7:0]       op;          // Captured opcode
    logic [23:0]      addr;        // Captured address
    logic [7:0]       last_byte;   // Last whole byte
    logic [7:0]       pp_ptr;      // Page byte pointer
    logic [ADDR_W-1:0] rd_addr;    // Next read address
    logic [7:0]       tx;          // Byte being shifted out
    logic             so_en;       // Output phase active
    logic             tog;         // Frame toggle to system side
    logic [5:0]       st_q1, st_q2, st_q3, st_s;   // Status sync
    logic [2:0]       next_bit_cnt, cur_bit;
    logic [3:0]       next_byte_cnt, cur_byte;
    logic [7:0]       nb, next_op, next_last, next_pp_ptr, next_tx;
    logic [23:0]      next_addr;
    logic [ADDR_W-1:0] next_rd_addr, rd_start;
    logic             next_so_en, done_byte, rd_load, rd_rej, pp_wr;
    logic             pm_clr;      // Clear staging mask at program opcode
    logic [23:0]      addr_nb;     // Address with the byte just shifted in
    sfc_pkg::sfc_stat_t ls;        // Status as seen by the link
    sfc_pkg::sfc_stat_t cur_sys;   // Live status, system side

    assign ls = sfc_pkg::sfc_stat_t'(st_s);
    assign nb = {sh[6:0], i_si};

    // Link next-state: decode, address capture, output byte choice
    always_comb begin
        cur_bit       = started ? bit_cnt : 3'h0;
        cur_byte      = started ? byte_cnt : 4'h0;
        done_byte     = (cur_bit == 3'h7);
        next_bit_cnt  = cur_bit + 3'h1;
        next_byte_cnt = cur_byte;
        next_op       = op;
        next_addr     = addr;
        next_last     = last_byte;
        next_pp_ptr   = pp_ptr;
        next_tx       = tx;
        next_rd_addr  = rd_addr;
        next_so_en    = started ? so_en : 1'b0;
        rd_load       = 1'b0;
        rd_rej        = 1'b0;
        pp_wr         = 1'b0;
        rd_start      = rd_addr;
        pm_clr        = 1'b0;
        addr_nb       = {addr[15:0], nb};
        if (done_byte) begin
            next_last = nb;
            if (cur_byte != sfc_pkg::BYTES_MAX) begin
                next_byte_cnt = cur_byte + 4'h1;
            end
            if (cur_byte == 4'h0) begin
                next_op = nb;
            end else if (cur_byte < sfc_pkg::BYTES_ADDR) begin
                next_addr = {addr[15:0], nb};
            end
            // Status read: reload live status every byte
            if ((cur_byte == 4'h0 && nb == sfc_pkg::OP_STATUS_READ) ||
                (cur_byte != 4'h0 && op == sfc_pkg::OP_STATUS_READ)) begin
                next_tx    = {ls.status_lock_bit, 2'b00, ls.bp, ls.write_unlock_latch, ls.busy};
                next_so_en = 1'b1;
            end
            // First read byte after address (and dummy)
            if (op == sfc_pkg::OP_READ && cur_byte == 4'h3) begin
                rd_start = addr_nb[ADDR_W-1:0];
                rd_load  = !ls.busy;
                rd_rej   = ls.busy;
            end else if (op == sfc_pkg::OP_FAST_READ && cur_byte == 4'h4) begin
                rd_start = addr[ADDR_W-1:0];
                rd_load  = !ls.busy;
                rd_rej   = ls.busy;
            end else if ((op == sfc_pkg::OP_READ || op == sfc_pkg::OP_FAST_READ) && so_en) begin
                rd_load  = 1'b1;
            end
            if (rd_load) begin
                next_tx      = mem[rd_start];
                next_rd_addr = rd_start + ADDR_W'(1);
                next_so_en   = 1'b1;
            end
            // Page program staging, pointer wraps in page
            // Staging left alone while busy: the running cycle still reads it
            if (cur_byte == 4'h0 && nb == sfc_pkg::OP_PAGE_WRITE && !ls.busy) begin
                pm_clr      = 1'b1;
            end else if (op == sfc_pkg::OP_PAGE_WRITE && cur_byte == 4'h3) begin
                next_pp_ptr = nb;
            end else if (op == sfc_pkg::OP_PAGE_WRITE && cur_byte >= sfc_pkg::BYTES_ADDR && !ls.busy) begin
                pp_wr       = 1'b1;
                next_pp_ptr = pp_ptr + 8'h01;
            end
        end
    end

    // Frame-local flag, cleared while deselected
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            started <= 1'b0;
        end else begin
            started <= 1'b1;
        end
    end

    // Frame toggle, flips on each frame's first edge
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            tog <= 1'b0;
        end else begin
            tog <= started ? tog : ~tog;
        end
    end

    // Link registers, held after the frame for the system side
    always_ff @(posedge i_sck) begin
        bit_cnt   <= next_bit_cnt;
        byte_cnt  <= next_byte_cnt;
        sh        <= nb;
        op        <= next_op;
        addr      <= next_addr;
        last_byte <= next_last;
        pp_ptr    <= next_pp_ptr;
        tx        <= next_tx;
        rd_addr   <= next_rd_addr;
        so_en     <= next_so_en;
        st_q1     <= {cur_sys.status_lock_bit, cur_sys.bp, cur_sys.write_unlock_latch, cur_sys.busy};
        st_q2     <= st_q1;
        st_q3     <= st_q2;
        st_s      <= (~(st_q2 ^ st_q3) & st_q3) | ((st_q2 ^ st_q3) & st_s);
        // Fresh mask per accepted program keeps unsent bytes untouched
        if (pm_clr) begin
            pmask <= '0;
        end else if (pp_wr) begin
            pmask[pp_ptr] <= 1'b1;
        end
        if (pp_wr) begin
            pbuf[pp_ptr] <= nb;
        end
    end

    // Output on falling edge, released when deselected
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_so    <= 1'b0;
            o_so_oe <= 1'b0;
        end else begin
            o_so    <= tx[~bit_cnt];
            o_so_oe <= so_en;
        end
    end

    // System-domain state
    logic [2:0]         sy_q1, sy_q2, sy_q3, sy_lvl;   // {cs_n, wp_n, toggle}
    logic               seen;                          // Last frame handled
    sfc_pkg::sfc_state_t state, next_state;
    logic               write_unlock_latch, next_wel, status_lock_bit, next_srp;
    logic [2:0]         bp, next_bp;
    logic [7:0]         wsr_val, next_wsr_val;         // Pending status byte
    logic [ADDR_W:0]    cnt, next_cnt, last, next_last_cnt;
    logic [ADDR_W-1:0]  base, next_base;
    logic               next_seen, frame_end, whole, hw_lock;
    logic               mem_we;
    logic [ADDR_W-1:0]  mem_wa;
    logic [7:0]         mem_wd;
    sfc_pkg::sfc_frame_t fr;

    assign fr      = '{op: op, nbytes: byte_cnt, bits: bit_cnt, addr: addr, data: last_byte};
    assign cur_sys = '{status_lock_bit: status_lock_bit, bp: bp, write_unlock_latch: write_unlock_latch, busy: (state != sfc_pkg::SFC_IDLE)};
    assign whole   = (fr.bits == 3'h0);
    assign hw_lock = status_lock_bit && !sy_lvl[1];
    assign frame_end = sy_q2[2] && sy_q3[2] && !sy_lvl[2] && (sy_lvl[0] != seen);

    // System next-state: execute frames, run timed cycles
    always_comb begin
        next_state    = state;
        next_wel      = write_unlock_latch;
        next_srp      = status_lock_bit;
        next_bp       = bp;
        next_wsr_val  = wsr_val;
        next_cnt      = cnt + (ADDR_W+1)'(1);
        next_last_cnt = last;
        next_base     = base;
        next_seen     = (sy_q2[2] && sy_q3[2] && !sy_lvl[2]) ? sy_lvl[0] : seen;
        mem_we        = 1'b0;
        mem_wa        = base + cnt[ADDR_W-1:0];
        mem_wd        = sfc_pkg::ERASED;
        case (state)
            sfc_pkg::SFC_IDLE: begin
                next_cnt = '0;
                if (frame_end && whole && fr.nbytes == sfc_pkg::BYTES_CMD) begin
                    if (fr.op == sfc_pkg::OP_WRITE_UNLOCK) begin
                        next_wel = 1'b1;
                    end else if (fr.op == sfc_pkg::OP_WRITE_LOCK) begin
                        next_wel = 1'b0;
                    end else if (fr.op == sfc_pkg::OP_CHIP_CLEAR && write_unlock_latch && bp == 3'h0) begin
                        next_state    = sfc_pkg::SFC_ERASE;
                        next_base     = '0;
                        next_last_cnt = (ADDR_W+1)'(MEM_BYTES - 1);
                    end
                end else if (frame_end && whole && write_unlock_latch) begin
                    if (fr.op == sfc_pkg::OP_STATUS_WRITE && fr.nbytes == sfc_pkg::BYTES_WSR &&
                        !hw_lock) begin
                        next_state    = sfc_pkg::SFC_WSR;
                        next_wsr_val  = fr.data;
                        next_last_cnt = (ADDR_W+1)'(STATUS_WRITE_CYC - 1);
                    end else if (fr.op == sfc_pkg::OP_PAGE_WRITE &&
                                 fr.nbytes >= sfc_pkg::BYTES_FAST &&
                                 !prot_hit(fr.addr[ADDR_W-1:0], bp)) begin
                        next_state    = sfc_pkg::SFC_PROG;
                        next_base     = {fr.addr[ADDR_W-1:sfc_pkg::PAGE_AW], 8'h00};
                        next_last_cnt = (ADDR_W+1)'(PAGE_WRITE_CYC - 1);
                    end else if (fr.op == sfc_pkg::OP_SECTOR_CLEAR &&
                                 fr.nbytes == sfc_pkg::BYTES_ADDR &&
                                 !prot_hit(fr.addr[ADDR_W-1:0], bp)) begin
                        next_state    = sfc_pkg::SFC_ERASE;
                        next_base     = fr.addr[ADDR_W-1:0] & ~SEC_MASK;
                        next_last_cnt = (ADDR_W+1)'(SEC_BYTES - 1);
                    end
                end
            end
            sfc_pkg::SFC_WSR: begin
                if (cnt == last) begin
                    next_state = sfc_pkg::SFC_IDLE;
                    next_wel   = 1'b0;
                    next_bp    = wsr_val[sfc_pkg::SB_BP +: sfc_pkg::BP_W];
                    next_srp   = wsr_val[sfc_pkg::SB_SRP];
                end
            end
            sfc_pkg::SFC_PROG: begin
                // Copy only the bytes that arrived, one per clock
                if (cnt < (ADDR_W+1)'(PAGE_BYTES)) begin
                    mem_we = pmask[cnt[7:0]];
                    mem_wd = pbuf[cnt[7:0]];
                end
                if (cnt == last) begin
                    next_state = sfc_pkg::SFC_IDLE;
                    next_wel   = 1'b0;
                end
            end
            sfc_pkg::SFC_ERASE: begin
                mem_we = 1'b1;
                if (cnt == last) begin
                    next_state = sfc_pkg::SFC_IDLE;
                    next_wel   = 1'b0;
                end
            end
            default: begin
                next_state = sfc_pkg::SFC_IDLE;
            end
        endcase
    end

    // System registers
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            sy_q1   <= sfc_pkg::SYNC_RST;
            sy_q2   <= sfc_pkg::SYNC_RST;
            sy_q3   <= sfc_pkg::SYNC_RST;
            sy_lvl  <= sfc_pkg::SYNC_RST;
            seen    <= 1'b0;
            state   <= sfc_pkg::SFC_IDLE;
            write_unlock_latch     <= 1'b0;
            status_lock_bit     <= sfc_pkg::SRP_RST;
            bp      <= sfc_pkg::BP_RST;
            wsr_val <= 8'h00;
            cnt     <= '0;
            last    <= '0;
            base    <= '0;
        end else begin
            sy_q1   <= {i_cs_n, i_wp_n, tog};
            sy_q2   <= sy_q1;
            sy_q3   <= sy_q2;
            sy_lvl  <= (~(sy_q2 ^ sy_q3) & sy_q3) | ((sy_q2 ^ sy_q3) & sy_lvl);
            seen    <= next_seen;
            state   <= next_state;
            write_unlock_latch     <= next_wel;
            status_lock_bit     <= next_srp;
            bp      <= next_bp;
            wsr_val <= next_wsr_val;
            cnt     <= next_cnt;
            last    <= next_last_cnt;
            base    <= next_base;
        end
    end

    // Array write port
    always_ff @(posedge i_clk) begin
        if (mem_we) begin
            mem[mem_wa] <= mem_wd;
        end
    end

    // Checks on the system side, read checks on the link side
    logic [7:0] sbyte;
    assign sbyte = {cur_sys.status_lock_bit, 2'b00, cur_sys.bp, cur_sys.write_unlock_latch, cur_sys.busy};

    property p_busy_bit;
        @(posedge i_clk) disable iff (i_rst) sbyte[sfc_pkg::SB_BUSY] == (state != sfc_pkg::SFC_IDLE);
    endproperty
    a_busy_bit: assert property (p_busy_bit) else $error("busy bit wrong");

    property p_reserved;
        @(posedge i_clk) disable iff (i_rst) sbyte[6:5] == 2'b00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bits set");

    property p_wel_gate;
        @(posedge i_clk) disable iff (i_rst)
            (state == sfc_pkg::SFC_IDLE) ##1 (state != sfc_pkg::SFC_IDLE) |-> $past(write_unlock_latch);
    endproperty
    a_wel_gate: assert property (p_wel_gate) else $error("cycle without write latch");

    property p_hw_lock;
        @(posedge i_clk) disable iff (i_rst) $rose(state == sfc_pkg::SFC_WSR) |-> !$past(hw_lock);
    endproperty
    a_hw_lock: assert property (p_hw_lock) else $error("status write under lock");

    property p_wsr_len;
        @(posedge i_clk) disable iff (i_rst)
            $rose(state == sfc_pkg::SFC_WSR) |-> (state == sfc_pkg::SFC_WSR)[*8];
    endproperty
    a_wsr_len: assert property (p_wsr_len) else $error("status write too short");

    property p_wsr_end;
        @(posedge i_clk) disable iff (i_rst)
            $fell(state == sfc_pkg::SFC_WSR) |-> !write_unlock_latch && bp == $past(wsr_val[4:2]);
    endproperty
    a_wsr_end: assert property (p_wsr_end) else $error("status write end wrong");

    property p_prog_end;
        @(posedge i_clk) disable iff (i_rst) $fell(state == sfc_pkg::SFC_PROG) |-> !write_unlock_latch;
    endproperty
    a_prog_end: assert property (p_prog_end) else $error("latch kept after program");

    property p_chip_clear;
        @(posedge i_clk) disable iff (i_rst)
            $rose(state == sfc_pkg::SFC_ERASE) && op == sfc_pkg::OP_CHIP_CLEAR
            |-> $past(bp) == 3'h0;
    endproperty
    a_chip_clear: assert property (p_chip_clear) else $error("chip clear while protected");

    property p_prog_prot;
        @(posedge i_clk) disable iff (i_rst) mem_we |-> !prot_hit(mem_wa, bp);
    endproperty
    a_prog_prot: assert property (p_prog_prot) else $error("write into protected area");

    property p_rd_reject;
        @(posedge i_sck) disable iff (i_cs_n) rd_rej |=> !so_en;
    endproperty
    a_rd_reject: assert property (p_rd_reject) else $error("read served while busy");

    c_wsr:   cover property (@(posedge i_clk) disable iff (i_rst) $fell(state == sfc_pkg::SFC_WSR));
    c_prog:  cover property (@(posedge i_clk) disable iff (i_rst) $fell(state == sfc_pkg::SFC_PROG));
    c_erase: cover property (@(posedge i_clk) disable iff (i_rst) $rose(state == sfc_pkg::SFC_ERASE));
    c_read:  cover property (@(posedge i_sck) disable iff (i_cs_n) rd_load ##8 rd_load);
endmodule

/* tb/sfc_host.sv */
// Host controller model that drives the serial link of the flash block.
// Assumes the bench calls its tasks; link clock stands still outside frames.
`timescale 1ns/1ps
module sfc_host (
    // Select timing reference
    input  wire logic i_clk,
    // Link pins
    output logic      o_sck,
    output logic      o_cs_n,
    output logic      o_si,
    input  wire logic i_so
);
    // Idle link: clock low, deselected
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_si = 1'b0;
    end
    // Select the device
    task automatic start();
        @(negedge i_clk);
        o_cs_n = 1'b0;
        #30;
    endtask
    // One byte each way, MSB first, 48 ns link period
    task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            o_si = tx[i];
            #24;
            rx[i] = i_so;
            o_sck = 1'b1;
            #24;
            o_sck = 1'b0;
        end
    endtask
    // Deselect at a byte boundary, then a long gap
    task automatic stop();
        #24;
        @(negedge i_clk);
        o_cs_n = 1'b1;
        o_si = ~o_si;
        repeat (8) @(negedge i_clk);
    endtask
endmodule

/* tb/tb_serial_flash_status_read_program.sv */
// Self-checking bench for the flash instruction interpreter.
// Assumes the host model drives the link; shortened cycle counts.
`timescale 1ns/1ps
module tb_serial_flash_status_read_program;
    logic       i_clk, i_rst, i_wp_n, sck, cs_n, si, o_so, o_so_oe;
    int         fail_count, comparisons, cycles;
    logic [7:0] r, r2;
    // Device under test with short timings
    sfc_cmd #(.ADDR_W(12), .STATUS_WRITE_CYC(20), .PAGE_WRITE_CYC(260)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n), .i_si(si),
        .i_wp_n(i_wp_n), .o_so(o_so), .o_so_oe(o_so_oe));
    // Far side host
    sfc_host host (.i_clk(i_clk), .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(o_so));
    // 25 MHz clock
    initial begin
        i_clk = 1'b0;
        forever #20 i_clk = ~i_clk;
    end
    // Hang guard
    always @(posedge i_clk) begin
        cycles++;
        if (cycles == 60000) begin
            fail_count++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("compares %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e) begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    // Open a frame and send n leading bytes of b
    task automatic frame(input logic [63:0] b, input int n);
        host.start();
        for (int i = 0; i < n; i++) host.xfer(b[63-8*i -: 8], r2);
    endtask
    task automatic cmd(input logic [63:0] b, input int n);
        frame(b, n);
        host.stop();
    endtask
    task automatic rd_status(output logic [7:0] s);
        frame({sfc_pkg::OP_STATUS_READ, 56'h0}, 1);
        host.xfer(8'h00, s);
        host.stop();
    endtask
    // Poll until the busy flag clears
    task automatic wait_idle();
        for (int i = 0; i < 200; i++) begin
            rd_status(r);
            if (r[0] === 1'b0) return;
        end
        chk("busy_timeout", 8'h00, r);
    endtask
    task automatic sc_status_after_reset();
        frame({sfc_pkg::OP_STATUS_READ, 56'h0}, 1);
        #5;
        chk("status_oe", 8'h01, {7'h00, o_so_oe});
        host.xfer(8'h00, r);
        host.xfer(8'h00, r2);
        host.stop();
        chk("status_first", 8'h00, r);
        chk("status_repeat", 8'h00, r2);
    endtask
    task automatic sc_latch();
        cmd({sfc_pkg::OP_WRITE_UNLOCK, 56'h0}, 1);
        rd_status(r);
        chk("unlock", 8'h02, r);
        cmd({sfc_pkg::OP_WRITE_LOCK, 56'h0}, 1);
        cmd({sfc_pkg::OP_STATUS_WRITE, 8'h9C, 48'h0}, 2);
        wait_idle();
        chk("locked_write", 8'h00, r);
    endtask
    task automatic sc_status_write();
        cmd({sfc_pkg::OP_WRITE_UNLOCK, 56'h0}, 1);
        cmd({sfc_pkg::OP_STATUS_WRITE, 8'hFF, 48'h0}, 2);
        rd_status(r);
        chk("busy_shown", 8'h03, r);
        wait_idle();
        chk("written", 8'h9C, r);
        @(negedge i_clk) i_wp_n = 1'b0;
        cmd({sfc_pkg::OP_WRITE_UNLOCK, 56'h0}, 1);
        cmd({sfc_pkg::OP_STATUS_WRITE, 8'h00, 48'h0}, 2);
        wait_idle();
        chk("hw_locked", 8'h9E, r);
        @(negedge i_clk) i_wp_n = 1'b1;
        cmd({sfc_pkg::OP_STATUS_WRITE, 8'h00, 48'h0}, 2);
        wait_idle();
        chk("unprotected", 8'h00, r);
    endtask
    task automatic sc_program();
        cmd({sfc_pkg::OP_WRITE_UNLOCK, 56'h0}, 1);
        cmd({sfc_pkg::OP_PAGE_WRITE, 24'h000FFE, 24'hA1A2A3, 8'h0}, 7);
        frame({sfc_pkg::OP_READ, 24'h000F00, 32'h0}, 4);
        host.xfer(8'h00, r);
        chk("busy_read_oe", 8'h00, {7'h00, o_so_oe});
        host.stop();
        wait_idle();
        chk("prog_done", 8'h00, r);
        frame({sfc_pkg::OP_READ, 24'h000F00, 32'h0}, 4);
        host.xfer(8'h00, r);
        host.stop();
        chk("page_wrap", 8'hA3, r);
        frame({sfc_pkg::OP_FAST_READ, 24'h000FFE, 32'h0}, 5);
        host.xfer(8'h00, r);
        host.xfer(8'h00, r2);
        host.stop();
        chk("fast_first", 8'hA1, r);
        chk("fast_next", 8'hA2, r2);
    endtask
    // Protect bits block program and chip clear, then a clean chip clear
    task automatic sc_protect();
        cmd({sfc_pkg::OP_WRITE_UNLOCK, 56'h0}, 1);
        cmd({sfc_pkg::OP_STATUS_WRITE, 8'h04, 48'h0}, 2);
        wait_idle();
        cmd({sfc_pkg::OP_WRITE_UNLOCK, 56'h0}, 1);
        cmd({sfc_pkg::OP_CHIP_CLEAR, 56'h0}, 1);
        cmd({sfc_pkg::OP_PAGE_WRITE, 24'h000FFE, 8'h55, 24'h0}, 5);
        wait_idle();
        chk("prot_refused", 8'h06, r);
        frame({sfc_pkg::OP_READ, 24'h000FFE, 32'h0}, 4);
        host.xfer(8'h00, r);
        host.stop();
        chk("prot_kept", 8'hA1, r);
        cmd({sfc_pkg::OP_STATUS_WRITE, 8'h00, 48'h0}, 2);
        wait_idle();
        cmd({sfc_pkg::OP_WRITE_UNLOCK, 56'h0}, 1);
        cmd({sfc_pkg::OP_CHIP_CLEAR, 56'h0}, 1);
        wait_idle();
        chk("clear_done", 8'h00, r);
        frame({sfc_pkg::OP_READ, 24'h000FFE, 32'h0}, 4);
        host.xfer(8'h00, r);
        host.stop();
        chk("cleared", 8'hFF, r);
    endtask
    // Main sequence
    initial begin
        i_rst = 1'b0;
        i_wp_n = 1'b1;
        // Clean rising reset edge before the first clock edge
        #10 i_rst = 1'b1;
        repeat (8) @(negedge i_clk);
        i_rst = 1'b0;
        repeat (6) @(negedge i_clk);
        sc_status_after_reset();
        sc_latch();
        sc_status_write();
        sc_program();
        sc_protect();
        give_verdict();
    end
endmodule
